// File: pkg/lsp_pkg.sv
/*
  Package of the segment-pin, charge-pump and interrupt-vector register block:
  register offsets, field positions, reset values, vector codes and carriers.
  Assumes a 32-bit AXI4-Lite register bus with each register on an aligned word.
*/
// Notes on behaviour
// - Segment enable bits 5..0: 0 keeps shared pin as port, 1 gives it to LCD.
// - Enable bits steer only shared pins; dedicated pins always stay LCD.
// - Pump clock sync bit 15 syncs pump clock while source on and fault-free.
// - Pump disable permit bits 7..0 let each function disable the pump.
// - Vector is 16-bit read-only and reads 00h with nothing pending.
// - Codes: 02h no capacitor, 04h blink off, 06h blink on, 08h frame.
// - Highest pending wins: 02h highest, 08h lowest, blink codes between.
// - Fields and vector reset to zero; reserved bits always read zero.
package lsp_pkg;

  localparam logic [3:0]  ADDR_SEG_EN   = 4'h0;
  localparam logic [3:0]  ADDR_PUMP     = 4'h4;
  localparam logic [3:0]  ADDR_IV       = 4'h8;
  localparam logic [3:0]  ADDR_FLAGS    = 4'hC;
  localparam logic [4:0]  ADDR_MASK     = 5'h10;
  localparam logic [4:0]  ADDR_CTRL     = 5'h14;

  localparam int          SEG_W         = 6;
  localparam int          PERMIT_W      = 8;
  localparam int          SYNC_BIT      = 15;
  localparam int          NUM_EVT       = 4;

  localparam logic [15:0] SEG_EN_RST    = 16'h0000;
  localparam logic [15:0] PUMP_RST      = 16'h0000;
  localparam logic [15:0] IV_NONE       = 16'h0000;
  localparam logic [15:0] IV_NOCAP      = 16'h0002;
  localparam logic [15:0] IV_BLK_OFF    = 16'h0004;
  localparam logic [15:0] IV_BLK_ON     = 16'h0006;
  localparam logic [15:0] IV_FRAME      = 16'h0008;

  localparam int          EVT_NOCAP     = 0;
  localparam int          EVT_BLK_OFF   = 1;
  localparam int          EVT_BLK_ON    = 2;
  localparam int          EVT_FRAME     = 3;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic                  aw_done;
    logic [4:0]            aw_addr;
    logic                  w_done;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  b_valid;
    logic [1:0]            b_resp;
    logic                  r_valid;
    logic [31:0]           r_data;
    logic [1:0]            r_resp;
    logic [SEG_W-1:0]      seg_en;
    logic                  pump_sync;
    logic [PERMIT_W-1:0]   permit;
    logic [NUM_EVT-1:0]    flags;
    logic [NUM_EVT-1:0]    mask;
    logic                  display_enable;
  } lsp_state_t;

  typedef struct packed {
    logic                  sync_clk_enabled;
    logic                  sync_clk_fault;
    logic [PERMIT_W-1:0]   disable_request;
  } lsp_pump_in_t;

  typedef struct packed {
    logic                  sync_active;
    logic                  pump_disable;
  } lsp_pump_out_t;

endpackage

// File: rtl/lsp_regs.sv
/*
  Segment-pin enable, charge-pump control and interrupt vector registers
  behind an AXI4-Lite slave, with sticky event flags, mask and one irq level.
  Assumes a master that keeps at most one read and one write under way.
*/
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module lsp_regs #(
  parameter logic [lsp_pkg::SEG_W-1:0] DEDICATED_MASK = '0
) (
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_b_in,
  // AXI4-Lite write
  input  wire logic                          s_awvalid_in,
  output logic                               s_awready_out,
  input  wire logic [4:0]                    s_awaddr_in,
  input  wire logic                          s_wvalid_in,
  output logic                               s_wready_out,
  input  wire logic [31:0]                   s_wdata_in,
  input  wire logic [3:0]                    s_wstrb_in,
  output logic                               s_bvalid_out,
  input  wire logic                          s_bready_in,
  output logic [1:0]                         s_bresp_out,
  // AXI4-Lite read
  input  wire logic                          s_arvalid_in,
  output logic                               s_arready_out,
  input  wire logic [4:0]                    s_araddr_in,
  output logic                               s_rvalid_out,
  input  wire logic                          s_rready_in,
  output logic [31:0]                        s_rdata_out,
  output logic [1:0]                         s_rresp_out,
  // Events, one-cycle or level, set sticky flags
  input  wire logic [lsp_pkg::NUM_EVT-1:0]   event_in,
  // Pin role and pump
  output logic [lsp_pkg::SEG_W-1:0]          pin_lcd_role_out,
  input  wire lsp_pkg::lsp_pump_in_t         pump_in,
  output lsp_pkg::lsp_pump_out_t             pump_out,
  // Display enable and interrupt
  output logic                               display_enable_out,
  output logic                               irq_out
);

  lsp_pkg::lsp_state_t st_reg;
  lsp_pkg::lsp_state_t st_next;
  logic [15:0]         vector;
  logic                wr_go;
  logic                rd_go;

  function automatic logic [15:0] pick_vector(input logic [lsp_pkg::NUM_EVT-1:0] f);
    if (f[lsp_pkg::EVT_NOCAP]) begin
      return lsp_pkg::IV_NOCAP;
    end else if (f[lsp_pkg::EVT_BLK_OFF]) begin
      return lsp_pkg::IV_BLK_OFF;
    end else if (f[lsp_pkg::EVT_BLK_ON]) begin
      return lsp_pkg::IV_BLK_ON;
    end else if (f[lsp_pkg::EVT_FRAME]) begin
      return lsp_pkg::IV_FRAME;
    end
    return lsp_pkg::IV_NONE;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Vector follows flags regardless of mask, like a polled source register
  assign vector = pick_vector(st_reg.flags);
  assign wr_go  = st_reg.aw_done && st_reg.w_done && !st_reg.b_valid;
  assign rd_go  = s_arvalid_in && !st_reg.r_valid;

  always_comb begin
    logic [31:0]                  cur;
    logic [31:0]                  wv;
    logic [lsp_pkg::NUM_EVT-1:0]  clr;
    cur     = '0;
    wv      = '0;
    clr     = '0;
    st_next = st_reg;
    if (s_awvalid_in && !st_reg.aw_done) begin
      st_next.aw_done = 1'b1;
      st_next.aw_addr = s_awaddr_in;
    end
    if (s_wvalid_in && !st_reg.w_done) begin
      st_next.w_done = 1'b1;
      st_next.w_data = s_wdata_in;
      st_next.w_strb = s_wstrb_in;
    end
    if (st_reg.b_valid && s_bready_in) begin
      st_next.b_valid = 1'b0;
    end
    if (st_reg.r_valid && s_rready_in) begin
      st_next.r_valid = 1'b0;
    end
    if (wr_go) begin
      st_next.aw_done = 1'b0;
      st_next.w_done  = 1'b0;
      st_next.b_valid = 1'b1;
      st_next.b_resp  = lsp_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        {1'b0, lsp_pkg::ADDR_SEG_EN}: begin
          cur = {26'h0, st_reg.seg_en};
          wv  = merge(cur, st_reg.w_data, st_reg.w_strb);
          st_next.seg_en = wv[lsp_pkg::SEG_W-1:0];
        end
        {1'b0, lsp_pkg::ADDR_PUMP}: begin
          cur = {16'h0000, st_reg.pump_sync, 7'h00, st_reg.permit};
          wv  = merge(cur, st_reg.w_data, st_reg.w_strb);
          st_next.pump_sync = wv[lsp_pkg::SYNC_BIT];
          st_next.permit    = wv[lsp_pkg::PERMIT_W-1:0];
        end
        {1'b0, lsp_pkg::ADDR_IV}: begin
          st_next.b_resp = lsp_pkg::RESP_SLVERR;
        end
        {1'b0, lsp_pkg::ADDR_FLAGS}: begin
          if (st_reg.w_strb[0]) begin
            clr = st_reg.w_data[lsp_pkg::NUM_EVT-1:0];
          end
        end
        lsp_pkg::ADDR_MASK: begin
          if (st_reg.w_strb[0]) begin
            st_next.mask = st_reg.w_data[lsp_pkg::NUM_EVT-1:0];
          end
        end
        lsp_pkg::ADDR_CTRL: begin
          if (st_reg.w_strb[0]) begin
            st_next.display_enable = st_reg.w_data[0];
          end
        end
        default: st_next.b_resp = lsp_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      st_next.r_valid = 1'b1;
      st_next.r_resp  = lsp_pkg::RESP_OKAY;
      unique case (s_araddr_in)
        {1'b0, lsp_pkg::ADDR_SEG_EN}: st_next.r_data = {26'h0, st_reg.seg_en};
        {1'b0, lsp_pkg::ADDR_PUMP}:
          st_next.r_data = {16'h0000, st_reg.pump_sync, 7'h00, st_reg.permit};
        {1'b0, lsp_pkg::ADDR_IV}: begin
          st_next.r_data = {16'h0000, vector};
          for (int i = 0; i < lsp_pkg::NUM_EVT; i++) begin
            if (vector == pick_vector(lsp_pkg::NUM_EVT'(1 << i))
                && vector != lsp_pkg::IV_NONE) begin
              clr[i] = 1'b1;
            end
          end
        end
        {1'b0, lsp_pkg::ADDR_FLAGS}: st_next.r_data = {28'h0000000, st_reg.flags};
        lsp_pkg::ADDR_MASK:          st_next.r_data = {28'h0000000, st_reg.mask};
        lsp_pkg::ADDR_CTRL:          st_next.r_data = {31'h0, st_reg.display_enable};
        default: begin
          st_next.r_data = 32'h00000000;
          st_next.r_resp = lsp_pkg::RESP_SLVERR;
        end
      endcase
    end
    // A new event in the clearing cycle wins over the clear
    st_next.flags = (st_reg.flags & ~clr) | event_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg                <= '0;
      st_reg.seg_en         <= lsp_pkg::SEG_EN_RST[lsp_pkg::SEG_W-1:0];
      st_reg.pump_sync      <= lsp_pkg::PUMP_RST[lsp_pkg::SYNC_BIT];
      st_reg.permit         <= lsp_pkg::PUMP_RST[lsp_pkg::PERMIT_W-1:0];
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_awready_out     = !st_reg.aw_done;
  assign s_wready_out      = !st_reg.w_done;
  assign s_bvalid_out      = st_reg.b_valid;
  assign s_bresp_out       = st_reg.b_resp;
  assign s_arready_out     = !st_reg.r_valid;
  assign s_rvalid_out      = st_reg.r_valid;
  assign s_rdata_out       = st_reg.r_data;
  assign s_rresp_out       = st_reg.r_resp;
  assign display_enable_out = st_reg.display_enable;
  assign irq_out           = |(st_reg.flags & st_reg.mask);

  // Dedicated pins ignore their enable bit
  assign pin_lcd_role_out = st_reg.seg_en | DEDICATED_MASK;

  assign pump_out.sync_active  = st_reg.pump_sync && pump_in.sync_clk_enabled
                                 && !pump_in.sync_clk_fault;
  assign pump_out.pump_disable = |(st_reg.permit & pump_in.disable_request);

  property p_vec_prio;
    @(posedge clk_in) disable iff (!rst_b_in)
      st_reg.flags[lsp_pkg::EVT_NOCAP] |-> vector == lsp_pkg::IV_NOCAP;
  endproperty
  a_vec_prio: assert property (p_vec_prio) else $error("vector priority wrong");

  property p_vec_none;
    @(posedge clk_in) disable iff (!rst_b_in)
      (st_reg.flags == '0) |-> vector == lsp_pkg::IV_NONE;
  endproperty
  a_vec_none: assert property (p_vec_none) else $error("vector not zero when idle");

  property p_vec_frame;
    @(posedge clk_in) disable iff (!rst_b_in)
      (st_reg.flags == 4'h8) |-> vector == lsp_pkg::IV_FRAME;
  endproperty
  a_vec_frame: assert property (p_vec_frame) else $error("frame code wrong");

  property p_blk;
    @(posedge clk_in) disable iff (!rst_b_in)
      (st_reg.flags[1:0] == 2'h0 && st_reg.flags[2]) |-> vector == lsp_pkg::IV_BLK_ON;
  endproperty
  a_blk: assert property (p_blk) else $error("blink on code wrong");

  property p_rd_clear;
    @(posedge clk_in) disable iff (!rst_b_in)
      (rd_go && s_araddr_in == {1'b0, lsp_pkg::ADDR_IV} && st_reg.flags[0] && !event_in[0])
        |=> !st_reg.flags[0] && s_rdata_out[15:0] == lsp_pkg::IV_NOCAP;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("vector read did not clear");

  property p_sync;
    @(posedge clk_in) disable iff (!rst_b_in)
      pump_in.sync_clk_fault |-> !pump_out.sync_active;
  endproperty
  a_sync: assert property (p_sync) else $error("sync during fault");

  property p_permit;
    @(posedge clk_in) disable iff (!rst_b_in)
      (st_reg.permit == '0) |-> !pump_out.pump_disable;
  endproperty
  a_permit: assert property (p_permit) else $error("unpermitted pump disable");

  property p_pin;
    @(posedge clk_in) disable iff (!rst_b_in)
      (pin_lcd_role_out & DEDICATED_MASK) == DEDICATED_MASK;
  endproperty
  a_pin: assert property (p_pin) else $error("dedicated pin lost role");

  property p_resv;
    @(posedge clk_in) disable iff (!rst_b_in)
      (st_reg.r_valid && st_reg.r_resp == lsp_pkg::RESP_OKAY && st_reg.r_data[31:16] != '0)
        |-> 1'b0;
  endproperty
  a_resv: assert property (p_resv) else $error("upper bits not zero");

  property p_vec_blk_off;
    @(posedge clk_in) disable iff (!rst_b_in)
      (!st_reg.flags[lsp_pkg::EVT_NOCAP] && st_reg.flags[lsp_pkg::EVT_BLK_OFF])
        |-> vector == lsp_pkg::IV_BLK_OFF;
  endproperty
  a_vec_blk_off: assert property (p_vec_blk_off) else $error("blink off code wrong");

  property p_iv_ro;
    @(posedge clk_in) disable iff (!rst_b_in)
      (wr_go && st_reg.aw_addr == {1'b0, lsp_pkg::ADDR_IV})
        |=> s_bresp_out == lsp_pkg::RESP_SLVERR;
  endproperty
  a_iv_ro: assert property (p_iv_ro) else $error("vector write not refused");

  property p_seg_wr;
    @(posedge clk_in) disable iff (!rst_b_in)
      (wr_go && st_reg.aw_addr == {1'b0, lsp_pkg::ADDR_SEG_EN} && st_reg.w_strb[0])
        |=> {26'h0, st_reg.seg_en} == ($past(st_reg.w_data) & 32'h0000003F);
  endproperty
  a_seg_wr: assert property (p_seg_wr) else $error("segment enable write lost");

  property p_pump_wr;
    @(posedge clk_in) disable iff (!rst_b_in)
      (wr_go && st_reg.aw_addr == {1'b0, lsp_pkg::ADDR_PUMP} && st_reg.w_strb[1:0] == 2'h3)
        |=> {16'h0000, st_reg.pump_sync, 7'h0, st_reg.permit}
            == ($past(st_reg.w_data) & 32'h000080FF);
  endproperty
  a_pump_wr: assert property (p_pump_wr) else $error("pump control write lost");

  property p_vec_rd;
    @(posedge clk_in) disable iff (!rst_b_in)
      (rd_go && s_araddr_in == {1'b0, lsp_pkg::ADDR_IV})
        |=> s_rdata_out == {16'h0000, $past(vector)};
  endproperty
  a_vec_rd: assert property (p_vec_rd) else $error("vector read data wrong");

  property p_resv_seg;
    @(posedge clk_in) disable iff (!rst_b_in)
      (rd_go && s_araddr_in == {1'b0, lsp_pkg::ADDR_SEG_EN})
        |=> (s_rdata_out & 32'hFFFFFFC0) == 32'h00000000;
  endproperty
  a_resv_seg: assert property (p_resv_seg) else $error("segment reserved bits set");

  property p_resv_pump;
    @(posedge clk_in) disable iff (!rst_b_in)
      (rd_go && s_araddr_in == {1'b0, lsp_pkg::ADDR_PUMP})
        |=> (s_rdata_out & 32'hFFFF7F00) == 32'h00000000;
  endproperty
  a_resv_pump: assert property (p_resv_pump) else $error("pump reserved bits set");

  // A flag must survive a clear that lands in the same cycle as its event
  property p_set_wins;
    @(posedge clk_in) disable iff (!rst_b_in)
      (event_in != '0) |=> (st_reg.flags & $past(event_in)) == $past(event_in);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event flag lost");

  property p_wr_ans;
    @(posedge clk_in) disable iff (!rst_b_in)
      wr_go |=> s_bvalid_out;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write response missing");

  property p_rd_ans;
    @(posedge clk_in) disable iff (!rst_b_in)
      rd_go |=> s_rvalid_out;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read response missing");

endmodule

// File: verification/lsp_tb.sv
/*
  Self-checking bench for the segment-pin, charge-pump and vector register block.
  Assumes the single-clock AXI4-Lite slave of the package; registers are byte-addressed.
*/
`timescale 1ns/1ps
module testbench;
  logic                          clk_in = 1'b0;
  logic                          rst_b_in = 1'b0;
  logic                          s_awvalid_in, s_awready_out, s_wvalid_in, s_wready_out;
  logic                          s_bvalid_out, s_bready_in, s_arvalid_in, s_arready_out;
  logic                          s_rvalid_out, s_rready_in, display_enable_out, irq_out;
  logic [4:0]                    s_awaddr_in, s_araddr_in;
  logic [31:0]                   s_wdata_in, s_rdata_out;
  logic [3:0]                    s_wstrb_in, event_in;
  logic [1:0]                    s_bresp_out, s_rresp_out;
  logic [lsp_pkg::SEG_W-1:0]     pin_lcd_role_out;
  lsp_pkg::lsp_pump_in_t         pump_in;
  lsp_pkg::lsp_pump_out_t        pump_out;
  int                            n_fail = 0;
  int                            checked = 0;
  localparam logic [5:0]         DED = 6'h21;

  always #2 clk_in = ~clk_in;

  lsp_regs #(.DEDICATED_MASK(DED)) DUT (
    .clk_in(clk_in), .rst_b_in(rst_b_in),
    .s_awvalid_in(s_awvalid_in), .s_awready_out(s_awready_out), .s_awaddr_in(s_awaddr_in),
    .s_wvalid_in(s_wvalid_in), .s_wready_out(s_wready_out), .s_wdata_in(s_wdata_in),
    .s_wstrb_in(s_wstrb_in), .s_bvalid_out(s_bvalid_out), .s_bready_in(s_bready_in),
    .s_bresp_out(s_bresp_out), .s_arvalid_in(s_arvalid_in), .s_arready_out(s_arready_out),
    .s_araddr_in(s_araddr_in), .s_rvalid_out(s_rvalid_out), .s_rready_in(s_rready_in),
    .s_rdata_out(s_rdata_out), .s_rresp_out(s_rresp_out), .event_in(event_in),
    .pin_lcd_role_out(pin_lcd_role_out), .pump_in(pump_in), .pump_out(pump_out),
    .display_enable_out(display_enable_out), .irq_out(irq_out));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, where both sides are settled;
  // what is seen there is what the next rising edge acts on. Only the
  // watchdog ends a wait, so a slave that never answers fails the run.
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       aw_hit;
    logic       w_hit;
    logic       b_hit;
    logic [1:0] resp;
    b_hit = 1'b0;
    @(posedge clk_in);
    s_awaddr_in  <= a;
    s_wdata_in   <= d;
    s_wstrb_in   <= 4'hF;
    s_awvalid_in <= 1'b1;
    s_wvalid_in  <= 1'b1;
    s_bready_in  <= 1'b1;
    while (!b_hit) begin
      @(negedge clk_in);
      aw_hit = s_awvalid_in && s_awready_out;
      w_hit  = s_wvalid_in && s_wready_out;
      b_hit  = s_bvalid_out && s_bready_in;
      resp   = s_bresp_out;
      @(posedge clk_in);
      if (aw_hit) s_awvalid_in <= 1'b0;
      if (w_hit) s_wvalid_in <= 1'b0;
      if (b_hit) s_bready_in <= 1'b0;
    end
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ar_hit;
    logic        r_hit;
    logic [31:0] data;
    logic [1:0]  resp;
    r_hit = 1'b0;
    @(posedge clk_in);
    s_araddr_in  <= a;
    s_arvalid_in <= 1'b1;
    s_rready_in  <= 1'b1;
    while (!r_hit) begin
      @(negedge clk_in);
      ar_hit = s_arvalid_in && s_arready_out;
      r_hit  = s_rvalid_out && s_rready_in;
      data   = s_rdata_out;
      resp   = s_rresp_out;
      @(posedge clk_in);
      if (ar_hit) s_arvalid_in <= 1'b0;
      if (r_hit) s_rready_in <= 1'b0;
    end
    chk(data, ed);
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic pulse(input logic [3:0] e);
    @(posedge clk_in);
    event_in <= e;
    @(posedge clk_in);
    event_in <= 4'h0;
    @(negedge clk_in);
  endtask

  task automatic t_reset;
    chk({26'h0, pin_lcd_role_out}, {26'h0, DED});
    axi_rd(5'h00, 32'h0, lsp_pkg::RESP_OKAY);
    axi_rd({1'b0, lsp_pkg::ADDR_PUMP}, 32'h0, lsp_pkg::RESP_OKAY);
    axi_rd({1'b0, lsp_pkg::ADDR_IV}, 32'h0, lsp_pkg::RESP_OKAY);
    chk({31'h0, irq_out}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_seg;
    axi_wr(lsp_pkg::ADDR_CTRL, 32'h0, lsp_pkg::RESP_OKAY);
    axi_wr(5'h00, 32'hFFFF_FFFF, lsp_pkg::RESP_OKAY);
    axi_rd(5'h00, 32'h0000_003F, lsp_pkg::RESP_OKAY);
    chk({26'h0, pin_lcd_role_out}, 32'h3F);
    axi_wr(5'h00, 32'h0000_0002, lsp_pkg::RESP_OKAY);
    chk({26'h0, pin_lcd_role_out}, 32'h23);
    axi_wr(lsp_pkg::ADDR_CTRL, 32'h1, lsp_pkg::RESP_OKAY);
    chk({31'h0, display_enable_out}, 32'h1);
    axi_rd(lsp_pkg::ADDR_CTRL, 32'h1, lsp_pkg::RESP_OKAY);
    axi_wr(lsp_pkg::ADDR_CTRL, 32'h0, lsp_pkg::RESP_OKAY);
    chk({31'h0, display_enable_out}, 32'h0);
    $display("test segment enable done");
  endtask

  task automatic t_pump;
    axi_wr({1'b0, lsp_pkg::ADDR_PUMP}, 32'hFFFF_FFFF, lsp_pkg::RESP_OKAY);
    axi_rd({1'b0, lsp_pkg::ADDR_PUMP}, 32'h0000_80FF, lsp_pkg::RESP_OKAY);
    @(posedge clk_in);
    pump_in <= '{1'b1, 1'b0, 8'h00};
    @(negedge clk_in);
    chk({31'h0, pump_out.sync_active}, 32'h1);
    @(posedge clk_in);
    pump_in <= '{1'b1, 1'b1, 8'h00};
    @(negedge clk_in);
    chk({31'h0, pump_out.sync_active}, 32'h0);
    @(posedge clk_in);
    pump_in <= '{1'b0, 1'b0, 8'h00};
    @(negedge clk_in);
    chk({31'h0, pump_out.sync_active}, 32'h0);
    axi_wr({1'b0, lsp_pkg::ADDR_PUMP}, 32'h0000_0055, lsp_pkg::RESP_OKAY);
    @(posedge clk_in);
    pump_in <= '{1'b1, 1'b0, 8'hAA};
    @(negedge clk_in);
    chk({30'h0, pump_out}, 32'h0);
    @(posedge clk_in);
    pump_in <= '{1'b1, 1'b0, 8'h04};
    @(negedge clk_in);
    chk({30'h0, pump_out}, 32'h1);
    $display("test pump done");
  endtask

  task automatic t_vec;
    axi_wr(lsp_pkg::ADDR_MASK, 32'hF, lsp_pkg::RESP_OKAY);
    pulse(4'hF);
    chk({31'h0, irq_out}, 32'h1);
    axi_rd({1'b0, lsp_pkg::ADDR_IV}, 32'h2, lsp_pkg::RESP_OKAY);
    axi_rd({1'b0, lsp_pkg::ADDR_IV}, 32'h4, lsp_pkg::RESP_OKAY);
    axi_rd({1'b0, lsp_pkg::ADDR_IV}, 32'h6, lsp_pkg::RESP_OKAY);
    axi_rd({1'b0, lsp_pkg::ADDR_IV}, 32'h8, lsp_pkg::RESP_OKAY);
    axi_rd({1'b0, lsp_pkg::ADDR_IV}, 32'h0, lsp_pkg::RESP_OKAY);
    chk({31'h0, irq_out}, 32'h0);
    axi_wr({1'b0, lsp_pkg::ADDR_IV}, 32'h8, lsp_pkg::RESP_SLVERR);
    axi_rd({1'b0, lsp_pkg::ADDR_IV}, 32'h0, lsp_pkg::RESP_OKAY);
    axi_rd(5'h18, 32'h0, lsp_pkg::RESP_SLVERR);
    $display("test vector done");
  endtask

  task automatic t_irq;
    axi_wr(lsp_pkg::ADDR_MASK, 32'h0, lsp_pkg::RESP_OKAY);
    pulse(4'h8);
    chk({31'h0, irq_out}, 32'h0);
    axi_rd({1'b0, lsp_pkg::ADDR_FLAGS}, 32'h8, lsp_pkg::RESP_OKAY);
    axi_wr(lsp_pkg::ADDR_MASK, 32'h8, lsp_pkg::RESP_OKAY);
    chk({31'h0, irq_out}, 32'h1);
    axi_rd(lsp_pkg::ADDR_MASK, 32'h8, lsp_pkg::RESP_OKAY);
    axi_wr({1'b0, lsp_pkg::ADDR_FLAGS}, 32'h8, lsp_pkg::RESP_OKAY);
    chk({31'h0, irq_out}, 32'h0);
    axi_rd({1'b0, lsp_pkg::ADDR_IV}, 32'h0, lsp_pkg::RESP_OKAY);
    $display("test interrupt done");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    s_awvalid_in = 1'b0;
    s_wvalid_in  = 1'b0;
    s_bready_in  = 1'b0;
    s_arvalid_in = 1'b0;
    s_rready_in  = 1'b0;
    s_awaddr_in  = 5'h0;
    s_araddr_in  = 5'h0;
    s_wdata_in   = 32'h0;
    s_wstrb_in   = 4'h0;
    event_in     = 4'h0;
    pump_in      = '0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_reset;
    t_seg;
    t_pump;
    t_vec;
    t_irq;
    close_out;
  end

  // Twenty-eight bus cycles of a few clocks each; this leaves wide margin
  initial begin
    #40000;
    n_fail++;
    close_out;
  end
endmodule
